// >>> verilog/pll_ctrl_regs.vh
// Register map, field positions, reset values and timing counts of the loop controller
`ifndef PLL_CTRL_REGS_VH
`define PLL_CTRL_REGS_VH

// ****************************************
// Bus geometry
// ****************************************
`define AXI_AW            5
`define AXI_DW            32
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL          5'h00
`define OFS_BW            5'h04
`define OFS_PROG          5'h08
`define OFS_STAT          5'h0c

// ****************************************
// Control register fields
// ****************************************
`define CTRL_IE           7
`define CTRL_FLAG         6
`define CTRL_PWR          5
`define CTRL_BCS          4
`define CTRL_UNUSED       4'hf

// ****************************************
// Bandwidth register fields
// ****************************************
`define BW_AUTO           7
`define BW_LOCK           6
`define BW_TRACK          5

// ****************************************
// Programming register fields and reset values
// ****************************************
`define PROG_MUL_HI       7
`define PROG_MUL_LO       4
`define PROG_VRS_HI       3
`define PROG_VRS_LO       0
`define MUL_RESET         4'h6
`define VRS_RESET         4'h6
`define MUL_ZERO          4'h0
`define MUL_ONE           4'h1

// ****************************************
// Base clock switch
// ****************************************
`define SW_EDGES          2'h3
`define SW_RUN            2'h0
`define SW_OLD            2'h1
`define SW_NEW            2'h2

`endif

// >>> verilog/pll_program_and_lock_control.v
// Loop programming, lock flag and glitch-free base clock switch with AXI4-Lite registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pll_ctrl_regs.vh"

// Contract
// - Multiplier field codes one to fifteen give N equal to the code.
// - Multiplier code zero behaves exactly as code one.
// - Reset loads multiplier field with six.
// - Multiplier writes ignored while loop power-on is set.
// - Range field sets multiplier L; writes ignored while loop power-on is set.
// - Reset loads range field with six.
// - Range zero disables the loop and clears base select.
// - Range zero refuses setting base select to the VCO clock.
// - In automatic mode every lock change sets the lock-change flag.
// - Interrupt raised on lock change only when lock interrupt enable set.
// - Automatic mode off suppresses interrupts; flag reads zero.
// - VCO clock selectable without lock check; software confirms lock first.
// - Wait mode leaves loop and base-clock settings running unchanged.
// - Stop disables generator; crystal, base clock and interrupt held low.
// - Stop clears base select; after recovery crystal half-rate drives output.
// - Break with flag-clear enabled: control reads clear flag, stays cleared.
// - Break with flag-clear disabled: control accesses leave flag unchanged.
// - Automatic mode: acquisition end shown by tracking indicator set.
// - Automatic mode: lock time end shown by lock indicator set.
// - Any control register read clears the flag outside protected break; a lock change in the read cycle sets it instead.
// - Base select cannot be set while loop power-on is clear.

module pll_program_and_lock_control (
   // Clock and reset
   input  wire                 aclk,
   input  wire                 aresetn,
   // AXI4-Lite write address
   input  wire [`AXI_AW-1:0]   s_axi_awaddr,
   input  wire                 s_axi_awvalid,
   output wire                 s_axi_awready,
   // AXI4-Lite write data
   input  wire [`AXI_DW-1:0]   s_axi_wdata,
   input  wire [3:0]           s_axi_wstrb,
   input  wire                 s_axi_wvalid,
   output wire                 s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0]           s_axi_bresp,
   output wire                 s_axi_bvalid,
   input  wire                 s_axi_bready,
   // AXI4-Lite read address
   input  wire [`AXI_AW-1:0]   s_axi_araddr,
   input  wire                 s_axi_arvalid,
   output wire                 s_axi_arready,
   // AXI4-Lite read data
   output wire [`AXI_DW-1:0]   s_axi_rdata,
   output wire [1:0]           s_axi_rresp,
   output wire                 s_axi_rvalid,
   input  wire                 s_axi_rready,
   // Analog loop status and source clocks
   input  wire                 lock_in,
   input  wire                 tracking_in,
   input  wire                 crystal_clock,
   input  wire                 vco_clock,
   // System mode inputs
   input  wire                 stop_mode,
   input  wire                 wait_mode,
   input  wire                 debug_break,
   input  wire                 break_flag_clear_enable,
   // Loop configuration outputs
   output wire                 loop_power_on,
   output wire                 auto_mode,
   output wire                 manual_tracking,
   output wire [3:0]           feedback_multiplier_n,
   output wire [3:0]           vco_range_l,
   // Clock and interrupt outputs
   output wire                 crystal_clock_out,
   output wire                 base_clock_out,
   output wire                 vco_selected,
   output wire                 lock_irq_request
);

   // ****************************************
   // Declarations
   // ****************************************
   reg                awready_r;
   reg                wready_r;
   reg                bvalid_r;
   reg  [1:0]         bresp_r;
   reg                aw_held_r;
   reg                w_held_r;
   reg  [`AXI_AW-1:0] awaddr_r;
   reg  [7:0]         wdata_r;
   reg                wstrb0_r;
   reg                arready_r;
   reg                rvalid_r;
   reg  [`AXI_DW-1:0] rdata_r;
   reg  [1:0]         rresp_r;

   reg                lock_irq_enable_r;
   reg                lock_change_flag_r;
   reg                loop_power_on_r;
   reg                base_clock_source_sel_r;
   reg                auto_r;
   reg                acq_manual_r;
   reg  [3:0]         feedback_multiplier_sel_r;
   reg  [3:0]         vco_range_sel_r;
   reg  [3:0]         mult_n_r;
   reg                lock_prev_r;
   reg                irq_r;
   reg                xclk_prev_r;
   reg                vclk_prev_r;
   reg                xclk_out_r;
   reg                base_out_r;
   reg                sel_act_r;
   reg  [1:0]         sw_state_r;
   reg  [1:0]         sw_cnt_r;

   reg  [7:0]         rd_byte;
   reg                rd_hit;

   wire aw_hs  = s_axi_awvalid & awready_r;
   wire w_hs   = s_axi_wvalid & wready_r;
   wire b_hs   = bvalid_r & s_axi_bready;
   wire ar_hs  = s_axi_arvalid & arready_r;
   wire r_hs   = rvalid_r & s_axi_rready;
   wire wr_go  = aw_held_r & w_held_r & ~bvalid_r;
   wire wr_hit = (awaddr_r[4:2] == `OFS_CTRL >> 2) | (awaddr_r[4:2] == `OFS_BW >> 2)
               | (awaddr_r[4:2] == `OFS_PROG >> 2) | (awaddr_r[4:2] == `OFS_STAT >> 2);
   wire wr_en  = wr_go & wstrb0_r;
   wire wr_ctrl = wr_en & (awaddr_r[4:2] == `OFS_CTRL >> 2);
   wire wr_bw   = wr_en & (awaddr_r[4:2] == `OFS_BW >> 2);
   wire wr_prog = wr_en & (awaddr_r[4:2] == `OFS_PROG >> 2);
   wire rd_ctrl = ar_hs & (s_axi_araddr[4:2] == `OFS_CTRL >> 2);

   wire range_zero = (vco_range_sel_r == `MUL_ZERO);
   wire lock_chg   = auto_r & (lock_in ^ lock_prev_r);
   // Flag is protected only during a break with flag clearing disabled
   wire clr_ok     = ~(debug_break & ~break_flag_clear_enable);
   wire x_rise     = crystal_clock & ~xclk_prev_r;
   // The VCO only runs while the loop is powered
   wire vclk_en    = vco_clock & loop_power_on_r;
   wire v_rise     = vclk_en & ~vclk_prev_r;
   wire old_rise   = sel_act_r ? v_rise : x_rise;
   wire new_rise   = base_clock_source_sel_r ? v_rise : x_rise;
   wire sw_busy    = (sw_state_r != `SW_RUN);

   // ****************************************
   // AXI4-Lite write channel
   // ****************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= `RESP_OKAY;
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= {`AXI_AW{1'b0}};
         wdata_r   <= 8'h00;
         wstrb0_r  <= 1'b0;
      end else begin
         if (aw_hs) begin
            awaddr_r  <= s_axi_awaddr;
            aw_held_r <= 1'b1;
            awready_r <= 1'b0;
         end
         if (w_hs) begin
            wdata_r  <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
            w_held_r <= 1'b1;
            wready_r <= 1'b0;
         end
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (b_hs) begin
            bvalid_r  <= 1'b0;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // ****************************************
   // AXI4-Lite read channel
   // ****************************************
   always @* begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      case (s_axi_araddr[4:2])
         `OFS_CTRL >> 2: begin
            // Enable and flag read as zero outside automatic mode
            rd_byte = {lock_irq_enable_r & auto_r,
                       lock_change_flag_r & auto_r,
                       loop_power_on_r, base_clock_source_sel_r, `CTRL_UNUSED};
         end
         `OFS_BW >> 2: begin
            rd_byte = {auto_r,
                       lock_in & auto_r,
                       auto_r ? tracking_in : acq_manual_r,
                       5'h00};
         end
         `OFS_PROG >> 2: begin
            rd_byte = {feedback_multiplier_sel_r, vco_range_sel_r};
         end
         `OFS_STAT >> 2: begin
            rd_byte = {sw_busy, sel_act_r, 2'h0, mult_n_r};
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= {`AXI_DW{1'b0}};
         rresp_r   <= `RESP_OKAY;
      end else begin
         if (ar_hs) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= {24'h000000, rd_byte};
            rresp_r   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (r_hs) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   // ****************************************
   // Control, bandwidth and programming state
   // ****************************************
   // Wait mode is deliberately not an input to any of this state
   always @(posedge aclk) begin
      if (!aresetn) begin
         lock_irq_enable_r         <= 1'b0;
         loop_power_on_r           <= 1'b1;
         base_clock_source_sel_r   <= 1'b0;
         auto_r                    <= 1'b0;
         acq_manual_r              <= 1'b0;
         feedback_multiplier_sel_r <= `MUL_RESET;
         vco_range_sel_r           <= `VRS_RESET;
      end else begin
         if (wr_ctrl) begin
            if (auto_r)
               lock_irq_enable_r <= wdata_r[`CTRL_IE];
            // Power cannot drop while base select is set
            if (!base_clock_source_sel_r)
               loop_power_on_r <= wdata_r[`CTRL_PWR];
            // Gating on the old power bit means selecting from off takes two writes
            if (!wdata_r[`CTRL_BCS])
               base_clock_source_sel_r <= 1'b0;
            else if (loop_power_on_r & ~range_zero)
               base_clock_source_sel_r <= 1'b1;
         end
         if (wr_bw) begin
            auto_r <= wdata_r[`BW_AUTO];
            // Manual value kept aside while automatic mode runs
            if (!auto_r)
               acq_manual_r <= wdata_r[`BW_TRACK];
         end
         if (wr_prog & ~loop_power_on_r) begin
            feedback_multiplier_sel_r <= wdata_r[`PROG_MUL_HI:`PROG_MUL_LO];
            vco_range_sel_r           <= wdata_r[`PROG_VRS_HI:`PROG_VRS_LO];
         end
         if (range_zero) begin
            loop_power_on_r         <= 1'b0;
            base_clock_source_sel_r <= 1'b0;
         end
         if (stop_mode)
            base_clock_source_sel_r <= 1'b0;
      end
   end

   // Effective feedback divide ratio
   always @(posedge aclk) begin
      if (!aresetn)
         mult_n_r <= `MUL_RESET;
      else if (feedback_multiplier_sel_r == `MUL_ZERO)
         mult_n_r <= `MUL_ONE;
      else
         mult_n_r <= feedback_multiplier_sel_r;
   end

   // ****************************************
   // Lock-change flag and interrupt
   // ****************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         lock_prev_r        <= 1'b0;
         lock_change_flag_r <= 1'b0;
         irq_r              <= 1'b0;
      end else begin
         lock_prev_r <= lock_in;
         // A change in the read cycle wins over the clear
         if (lock_chg)
            lock_change_flag_r <= 1'b1;
         else if (rd_ctrl & clr_ok)
            lock_change_flag_r <= 1'b0;
         irq_r <= lock_change_flag_r & lock_irq_enable_r & auto_r & ~stop_mode;
      end
   end

   // ****************************************
   // Glitch-free base clock switch
   // ****************************************
   // Source clocks are sampled, so they must be well below half of aclk
   always @(posedge aclk) begin
      if (!aresetn) begin
         xclk_prev_r <= 1'b0;
         vclk_prev_r <= 1'b0;
         xclk_out_r  <= 1'b0;
         base_out_r  <= 1'b0;
         sel_act_r   <= 1'b0;
         sw_state_r  <= `SW_RUN;
         sw_cnt_r    <= 2'h0;
      end else begin
         xclk_prev_r <= crystal_clock;
         vclk_prev_r <= vclk_en;
         xclk_out_r  <= crystal_clock & ~stop_mode;
         if (stop_mode) begin
            // Everything is parked low, so dropping the VCO here cannot glitch
            base_out_r <= 1'b0;
            sel_act_r  <= 1'b0;
            sw_state_r <= `SW_RUN;
            sw_cnt_r   <= 2'h0;
         end else begin
            case (sw_state_r)
               `SW_RUN: begin
                  if (base_clock_source_sel_r != sel_act_r) begin
                     sw_state_r <= `SW_OLD;
                     sw_cnt_r   <= 2'h0;
                  end else if (old_rise) begin
                     base_out_r <= ~base_out_r;
                  end
               end
               `SW_OLD: begin
                  // Output held in stasis; a dead VCO is not waited for
                  if (sel_act_r & ~loop_power_on_r) begin
                     sw_state_r <= `SW_NEW;
                     sw_cnt_r   <= 2'h0;
                  end else if (old_rise) begin
                     if (sw_cnt_r == `SW_EDGES - 2'h1) begin
                        sw_state_r <= `SW_NEW;
                        sw_cnt_r   <= 2'h0;
                     end else begin
                        sw_cnt_r <= sw_cnt_r + 2'h1;
                     end
                  end
               end
               `SW_NEW: begin
                  if (new_rise) begin
                     if (sw_cnt_r == `SW_EDGES - 2'h1) begin
                        sel_act_r  <= base_clock_source_sel_r;
                        sw_state_r <= `SW_RUN;
                        sw_cnt_r   <= 2'h0;
                     end else begin
                        sw_cnt_r <= sw_cnt_r + 2'h1;
                     end
                  end
               end
               default: begin
                  sw_state_r <= `SW_RUN;
                  sw_cnt_r   <= 2'h0;
               end
            endcase
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign s_axi_awready         = awready_r;
   assign s_axi_wready          = wready_r;
   assign s_axi_bresp           = bresp_r;
   assign s_axi_bvalid          = bvalid_r;
   assign s_axi_arready         = arready_r;
   assign s_axi_rdata           = rdata_r;
   assign s_axi_rresp           = rresp_r;
   assign s_axi_rvalid          = rvalid_r;
   assign loop_power_on         = loop_power_on_r;
   assign auto_mode             = auto_r;
   assign manual_tracking       = acq_manual_r;
   assign feedback_multiplier_n = mult_n_r;
   assign vco_range_l           = vco_range_sel_r;
   assign crystal_clock_out     = xclk_out_r;
   assign base_clock_out        = base_out_r;
   assign vco_selected          = sel_act_r;
   assign lock_irq_request      = irq_r;
endmodule // pll_program_and_lock_control
`default_nettype wire

// >>> bench/pll_ctrl_checker_assertions.sv
// Port-level checker for the loop programming and lock controller
`timescale 1ns/1ps
`default_nettype none
`include "pll_ctrl_regs.vh"

module pll_ctrl_checker (
   // Clock and reset
   input wire               aclk,
   input wire               aresetn,
   // Read channel
   input wire [`AXI_AW-1:0] s_axi_araddr,
   input wire               s_axi_arvalid,
   input wire               s_axi_arready,
   input wire [`AXI_DW-1:0] s_axi_rdata,
   input wire               s_axi_rvalid,
   // Loop side
   input wire               crystal_clock,
   input wire               stop_mode,
   input wire               loop_power_on,
   input wire               auto_mode,
   input wire [3:0]         feedback_multiplier_n,
   input wire [3:0]         vco_range_l,
   input wire               crystal_clock_out,
   input wire               base_clock_out,
   input wire               vco_selected,
   input wire               lock_irq_request
);
   // ****************************************
   // Helper logic
   // ****************************************
   reg rd_ctrl_r;

   always @(posedge aclk) begin
      if (!aresetn)
         rd_ctrl_r <= 1'b0;
      else if (s_axi_arvalid && s_axi_arready)
         rd_ctrl_r <= (s_axi_araddr[4:2] == 3'h0);
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ****************************************
   // Assertions
   // ****************************************
   a_irq_gated: assert property (lock_irq_request |-> $past(auto_mode) && !$past(stop_mode))
      else $error("interrupt raised without automatic mode or during stop");
   a_stop_low: assert property ($past(stop_mode) |->
         !crystal_clock_out && !base_clock_out && !vco_selected)
      else $error("clock outputs not held low in stop");
   a_xtal_follow: assert property ($past(aresetn) && !$past(stop_mode) |->
         crystal_clock_out == $past(crystal_clock))
      else $error("crystal output does not follow its source");
   a_prog_frozen: assert property (loop_power_on && $past(loop_power_on) |->
         $stable(feedback_multiplier_n) && $stable(vco_range_l))
      else $error("programming changed while loop on");
   a_range_zero_off: assert property (vco_range_l == 4'h0 |-> ##[0:1] !loop_power_on)
      else $error("loop left on with range zero");
   a_vco_guard: assert property ($rose(vco_selected) |->
         loop_power_on && vco_range_l != 4'h0)
      else $error("vco selected while loop off or range zero");
   a_n_never_zero: assert property (feedback_multiplier_n != 4'h0)
      else $error("multiplier shows zero");
   a_ctrl_rd_fmt: assert property (s_axi_rvalid && rd_ctrl_r |->
         s_axi_rdata[3:0] == 4'hf && (auto_mode || s_axi_rdata[7:6] == 2'h0))
      else $error("control read format wrong");
endmodule // pll_ctrl_checker

bind pll_program_and_lock_control pll_ctrl_checker i_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .crystal_clock(crystal_clock), .stop_mode(stop_mode), .loop_power_on(loop_power_on),
   .auto_mode(auto_mode), .feedback_multiplier_n(feedback_multiplier_n),
   .vco_range_l(vco_range_l), .crystal_clock_out(crystal_clock_out),
   .base_clock_out(base_clock_out), .vco_selected(vco_selected),
   .lock_irq_request(lock_irq_request));
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the loop programming and lock controller
`timescale 1ns/1ps
`default_nettype none
`include "pll_ctrl_regs.vh"

module testbench;
   reg                aclk, aresetn, awvalid, wvalid, arvalid;
   reg  [`AXI_AW-1:0] awaddr, araddr;
   reg  [`AXI_DW-1:0] wdata;
   reg                lock_in, tracking_in, crystal_clock, vco_clock;
   reg                stop_mode, wait_mode, debug_break, break_flag_clear_enable;
   reg  [2:0]         div;
   wire               awready, wready, bvalid, arready, rvalid;
   wire [1:0]         bresp, rresp;
   wire [`AXI_DW-1:0] rdata;
   wire               loop_power_on, auto_mode, manual_tracking;
   wire [3:0]         feedback_multiplier_n, vco_range_l;
   wire               crystal_clock_out, base_clock_out, vco_selected, lock_irq_request;
   integer            checks, bad_count, cyc_cnt, i, n, tg;
   reg                prev;
   reg  [31:0]        d;
   reg  [1:0]         r;

   pll_program_and_lock_control i_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .lock_in(lock_in), .tracking_in(tracking_in), .crystal_clock(crystal_clock),
      .vco_clock(vco_clock), .stop_mode(stop_mode), .wait_mode(wait_mode),
      .debug_break(debug_break), .break_flag_clear_enable(break_flag_clear_enable),
      .loop_power_on(loop_power_on), .auto_mode(auto_mode), .manual_tracking(manual_tracking),
      .feedback_multiplier_n(feedback_multiplier_n), .vco_range_l(vco_range_l),
      .crystal_clock_out(crystal_clock_out), .base_clock_out(base_clock_out),
      .vco_selected(vco_selected), .lock_irq_request(lock_irq_request));

   // ****************************************
   // Clocks and timeout
   // ****************************************
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // Source clocks slow enough for the level sampling inside the block
   always @(posedge aclk) begin
      div <= div + 3'h1;
      crystal_clock <= div[2];
      vco_clock <= div[1];
      cyc_cnt = cyc_cnt + 1;
      if (cyc_cnt == 6000) begin
         bad_count = bad_count + 1;
         test_done;
      end
   end

   // ****************************************
   // Tasks
   // ****************************************
   task test_done;
      begin
         $display("comparisons %0d mismatches %0d", checks, bad_count);
         if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task cyc(input integer k);
      begin
         repeat (k) @(posedge aclk);
      end
   endtask

   // Response readies are tied high, so only the valids move here
   task wr(input [4:0] a, input [7:0] v, input [1:0] er);
      reg aw, w, b;
      begin
         awaddr <= a;
         wdata <= {24'h0, v};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         aw = 1'b0;
         w = 1'b0;
         b = 1'b0;
         while (!b) begin
            @(posedge aclk);
            if (!aw && awready) begin
               aw = 1'b1;
               awvalid <= 1'b0;
            end
            if (!w && wready) begin
               w = 1'b1;
               wvalid <= 1'b0;
            end
            if (bvalid) begin
               b = 1'b1;
               chk(bresp, er);
            end
         end
      end
   endtask

   task rd(input [4:0] a, output [31:0] dv, output [1:0] rr);
      reg ar, got;
      begin
         araddr <= a;
         arvalid <= 1'b1;
         ar = 1'b0;
         got = 1'b0;
         while (!got) begin
            @(posedge aclk);
            if (!ar && arready) begin
               ar = 1'b1;
               arvalid <= 1'b0;
            end
            if (rvalid) begin
               got = 1'b1;
               dv = rdata;
               rr = rresp;
            end
         end
      end
   endtask

   task rdc(input [4:0] a, input [31:0] exp);
      begin
         rd(a, d, r);
         chk(d, exp);
      end
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = 0;
      {lock_in, tracking_in, crystal_clock, vco_clock, div} = 0;
      {stop_mode, wait_mode, debug_break, break_flag_clear_enable} = 0;
      checks = 0;
      bad_count = 0;
      cyc_cnt = 0;
      aresetn = 1'b0;
      cyc(10);
      aresetn <= 1'b1;
      cyc(2);
      rdc(5'h00, 32'h2f);
      rdc(5'h08, 32'h66);
      rdc(5'h0c, 32'h06);
      wr(5'h08, 8'h3a, 2'h0);
      rdc(5'h08, 32'h66);
      wr(5'h00, 8'h00, 2'h0);
      for (i = 0; i < 16; i = i + 1) begin
         wr(5'h08, {i[3:0], 4'h6}, 2'h0);
         rdc(5'h08, {24'h0, i[3:0], 4'h6});
         chk(feedback_multiplier_n, (i == 0) ? 1 : i);
      end
      wr(5'h08, 8'h40, 2'h0);
      wr(5'h00, 8'h20, 2'h0);
      cyc(2);
      chk(loop_power_on, 0);
      wr(5'h00, 8'h30, 2'h0);
      rdc(5'h00, 32'h0f);
      wr(5'h08, 8'h46, 2'h0);
      wr(5'h00, 8'h10, 2'h0);
      rdc(5'h00, 32'h0f);
      wr(5'h00, 8'h20, 2'h0);
      wr(5'h00, 8'h30, 2'h0);
      rdc(5'h00, 32'h3f);
      n = 0;
      while (vco_selected !== 1'b1 && n < 300) begin
         @(posedge aclk);
         n = n + 1;
      end
      rdc(5'h0c, 32'h44);
      wait_mode <= 1'b1;
      cyc(20);
      chk(vco_selected, 1);
      rdc(5'h00, 32'h3f);
      wait_mode <= 1'b0;
      stop_mode <= 1'b1;
      cyc(3);
      chk({crystal_clock_out, base_clock_out, vco_selected, lock_irq_request}, 0);
      rdc(5'h00, 32'h2f);
      stop_mode <= 1'b0;
      tg = 0;
      prev = 1'b0;
      repeat (64) begin
         @(posedge aclk);
         if (base_clock_out !== prev)
            tg = tg + 1;
         prev = base_clock_out;
      end
      chk(tg >= 7 && tg <= 9, 1);
      chk(vco_selected, 0);
      lock_in <= 1'b1;
      cyc(4);
      rdc(5'h00, 32'h2f);
      lock_in <= 1'b0;
      tracking_in <= 1'b1;
      wr(5'h04, 8'h80, 2'h0);
      wr(5'h00, 8'ha0, 2'h0);
      rdc(5'h00, 32'haf);
      lock_in <= 1'b1;
      cyc(4);
      chk(lock_irq_request, 1);
      rdc(5'h04, 32'he0);
      rdc(5'h00, 32'hef);
      rdc(5'h00, 32'haf);
      cyc(2);
      chk(lock_irq_request, 0);
      wr(5'h00, 8'h20, 2'h0);
      lock_in <= 1'b0;
      cyc(4);
      chk(lock_irq_request, 0);
      rdc(5'h00, 32'h6f);
      lock_in <= 1'b1;
      debug_break <= 1'b1;
      cyc(4);
      rdc(5'h00, 32'h6f);
      wr(5'h00, 8'h20, 2'h0);
      rdc(5'h00, 32'h6f);
      break_flag_clear_enable <= 1'b1;
      rdc(5'h00, 32'h6f);
      rdc(5'h00, 32'h2f);
      debug_break <= 1'b0;
      rdc(5'h00, 32'h2f);
      wr(5'h04, 8'h00, 2'h0);
      lock_in <= 1'b0;
      cyc(4);
      rdc(5'h00, 32'h2f);
      chk(lock_irq_request, 0);
      wr(5'h04, 8'h20, 2'h0);
      rdc(5'h04, 32'h20);
      chk({auto_mode, manual_tracking}, 2'h1);
      wr(5'h10, 8'hff, 2'h2);
      rd(5'h14, d, r);
      chk({r, d[7:0]}, {2'h2, 8'h00});
      test_done;
   end
endmodule // testbench
`default_nettype wire
